// File: common/dcff_pkg.sv
/*
 * dcff_pkg: shared constants and carrier types for the dual-clock fifo
 * with standard and fall-through flag modes.
 * assumes: included before the design files; no clocks or state here.
 */
package dcff_pkg;

    // data word width and default depth exponent (depth = 2**addr bits)
    localparam int DCFF_DATA_W = 36;
    localparam int DCFF_ADDR_W = 10;

    // default flag offsets after master reset
    localparam int DCFF_EMPTY_OFS_RST = 127;
    localparam int DCFF_FULL_OFS_RST = 127;

    // synchroniser depths for pointer crossings and flag pipelines
    localparam int DCFF_SYNC_STAGES = 2;
    localparam int DCFF_OR_STAGES = 3;
    localparam int DCFF_IR_STAGES = 2;

    // timing mode latched at master reset
    typedef enum logic [1:0] {
        DCFF_MODE_STD = 2'b01,
        DCFF_MODE_FALLTHROUGH_MODE = 2'b10
    } dcff_mode_t;

    // status flags as seen at the pins, all active low
    typedef struct packed {
        logic empty_n;      // standard empty, or fall-through output-ready
        logic full_n;       // standard full, or inverted fall-through input-space
        logic half_full_n;
        logic almost_empty_n;
        logic almost_full_n;
    } dcff_flags_t;

endpackage : dcff_pkg

// File: logic/dcff_fifo.sv
/*
 * dcff_fifo: dual-clock fifo core with standard and first-word-fall-through
 * flag timing, half-full and programmable almost flags.
 * assumes: writer on clk_sys, reader on link_clk (free running while the
 * reader is active); master reset pulse and straps come from outside.
 */
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - mode is captured at master reset: low standard, high fall-through
// - fall-through mode first word appears after three read clock edges
// - write enable low captures the input word on the write clock edge
// - standard empty flag rises once the first word is written
// - standard almost-empty rises when count reaches empty offset plus one
// - standard half-full falls when word depth/2+1 is written
// - standard almost-full falls after depth minus full offset writes
// - standard full falls after depth writes; further writes ignored
// - standard first read from full releases full; others rise at thresholds
// - standard almost-empty falls when exactly empty offset words remain
// - standard last read drives empty low; reads ignored while empty
// - standard empty and full pass a two-stage register synchroniser
// - fall-through output-ready goes low once the first word is valid
// - fall-through almost-empty rises once empty offset plus two are loaded
// - fall-through half-full falls when word depth/2+2 is written
// - fall-through almost-full falls after depth+1 minus full offset writes
// - fall-through input-space rises after depth+1 writes; writes then inhibited
// - fall-through first read from full drives input-space low
// - fall-through almost-empty falls at offset plus one; output-ready rises at end
// - fall-through output-ready has three stages, input-space two
// - synchronous flag timing: almost-full on write clock, almost-empty on read
module dcff_fifo
    import dcff_pkg::*;
#(
    parameter int DATA_W = DCFF_DATA_W,
    parameter int ADDR_W = DCFF_ADDR_W,
    parameter int EMPTY_OFS = DCFF_EMPTY_OFS_RST,
    parameter int FULL_OFS = DCFF_FULL_OFS_RST
) (
    input wire logic clk_sys,                          // write clock
    input wire logic rstn,                             // async reset, active low
    input wire logic clk_en,                           // freezes all state when low
    input wire logic link_clk,                         // read clock
    input wire logic master_reset_n,                   // master reset pin, active low
    input wire logic fallthrough_select_serial_in,     // mode strap, sampled at reset
    input wire logic flag_timing_select,               // high: synchronous almost flags
    input wire logic write_en_n,                       // write request, active low
    input wire logic [DATA_W-1:0] write_data,          // word to store
    input wire logic read_en_n,                        // read request, active low
    output logic [DATA_W-1:0] read_data_out,           // output data register
    output logic empty_flag_n,                         // standard empty, low = empty
    output logic full_flag_n,                          // standard full, low = full
    output logic output_ready_n,                       // fall-through data valid, low
    output logic input_space_n,                        // fall-through, high = no room
    output logic half_full_n,                          // low = more than half used
    output logic almost_empty_n,                       // low = near empty
    output logic almost_full_n,                        // low = near full
    output logic fallthrough_mode                      // latched mode, high = fall-through
);

    localparam int PTR_W = ADDR_W + 1;
    localparam logic [PTR_W-1:0] DEPTH = PTR_W'(1) << ADDR_W;
    localparam logic [PTR_W-1:0] HALF = DEPTH >> 1;
    localparam logic [PTR_W-1:0] AE_OFS = PTR_W'(EMPTY_OFS);
    localparam logic [PTR_W-1:0] AF_LVL = DEPTH - PTR_W'(FULL_OFS);

    function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : bin2gray

    function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
        logic [PTR_W-1:0] b;
        b = '0;
        for (int i = PTR_W - 1; i >= 0; i--) begin
            b[i] = (i == PTR_W - 1) ? g[i] : (b[i+1] ^ g[i]);
        end
        return b;
    endfunction : gray2bin

    // storage has no reset: a slot is read only after its write pointer has
    // crossed over, so whatever it held before is never shown
    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    // write domain state
    logic mr_w_meta_reg, mr_w_reg;
    logic ft_meta_reg, ft_sync_reg, pfm_meta_reg, pfm_sync_reg;
    logic [PTR_W-1:0] wbin_reg, wgray_reg;
    logic [PTR_W-1:0] rgray_w1_reg, rgray_w2_reg;
    logic [DATA_W-1:0] wdata_s1_reg, wdata_s2_reg;
    logic wen_s1_reg, wen_s2_reg;
    dcff_mode_t mode_reg;
    logic pfm_reg;
    logic full_raw_reg, full_s1_reg;
    logic af_raw_reg, hf_raw_reg;
    // output-valid mirrored from the read side for the fall-through word count
    logic ov_w1_reg, ov_w2_reg;

    // read domain state
    logic mr_r_meta_reg, mr_r_reg;
    logic mode_r_meta_reg, mode_r_reg;
    logic pfm_r_meta_reg, pfm_r_reg;
    logic ren_s1_reg, ren_s2_reg;
    logic [PTR_W-1:0] rbin_reg, rgray_reg;
    logic [PTR_W-1:0] wgray_r1_reg, wgray_r2_reg;
    logic out_valid_reg;
    logic [1:0] or_pipe_reg;
    logic empty_raw_reg, empty_s1_reg, ae_raw_reg;

    // write domain: master reset and straps pass two flops before use
    // write data rides the same two flops as its strobe, so word and request stay paired
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mr_w_meta_reg <= 1'b0;
            mr_w_reg <= 1'b0;
            ft_meta_reg <= 1'b0;
            ft_sync_reg <= 1'b0;
            pfm_meta_reg <= 1'b0;
            pfm_sync_reg <= 1'b0;
            wen_s1_reg <= 1'b1;
            wen_s2_reg <= 1'b1;
            wdata_s1_reg <= '0;
            wdata_s2_reg <= '0;
        end else if (clk_en) begin
            mr_w_meta_reg <= ~master_reset_n;
            mr_w_reg <= mr_w_meta_reg;
            ft_meta_reg <= fallthrough_select_serial_in;
            ft_sync_reg <= ft_meta_reg;
            pfm_meta_reg <= flag_timing_select;
            pfm_sync_reg <= pfm_meta_reg;
            wen_s1_reg <= write_en_n;
            wen_s2_reg <= wen_s1_reg;
            wdata_s1_reg <= write_data;
            wdata_s2_reg <= wdata_s1_reg;
        end
    end

    // latch mode in reset: reloaded from the straps each clock while master reset is low, then frozen
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mode_reg <= DCFF_MODE_STD;
            pfm_reg <= 1'b0;
        end else if (clk_en && mr_w_reg) begin
            mode_reg <= ft_sync_reg ? DCFF_MODE_FALLTHROUGH_MODE : DCFF_MODE_STD;
            pfm_reg <= pfm_sync_reg;
        end
    end

    logic is_ft_w;
    assign is_ft_w = (mode_reg == DCFF_MODE_FALLTHROUGH_MODE);

    // registered mode bit: the decode of the one-hot code can glitch while both
    // bits change, so only this flop drives the pin and feeds the read side
    logic ft_w_reg;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ft_w_reg <= 1'b0;
        end else if (clk_en) begin
            ft_w_reg <= is_ft_w;
        end
    end
    assign fallthrough_mode = ft_w_reg;

    // word count on the write side, in words held in memory
    logic [PTR_W-1:0] rbin_w, wcount, wcount_inc;
    logic do_write;
    assign rbin_w = gray2bin(rgray_w2_reg);
    assign wcount = wbin_reg - rbin_w;
    // the read pointer seen here lags by two edges, so full clears late, never early
    // write refused when full
    assign do_write = !wen_s2_reg && (wcount != DEPTH);
    assign wcount_inc = wcount + (do_write ? PTR_W'(1) : PTR_W'(0));

    always_ff @(posedge clk_sys) begin
        if (clk_en && do_write && !mr_w_reg) begin
            mem_reg[wbin_reg[ADDR_W-1:0]] <= wdata_s2_reg;
        end
    end

    // one bit moves per step, so a copy caught mid-change is off by one word at most
    // master reset clears the pointer; the mirrored copy settles before reset ends
    // gray write pointer, read pointer synchronised back
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wbin_reg <= '0;
            wgray_reg <= '0;
            rgray_w1_reg <= '0;
            rgray_w2_reg <= '0;
        end else if (clk_en) begin
            rgray_w1_reg <= rgray_reg;
            rgray_w2_reg <= rgray_w1_reg;
            if (mr_w_reg) begin
                wbin_reg <= '0;
                wgray_reg <= '0;
            end else if (do_write) begin
                wbin_reg <= wbin_reg + PTR_W'(1);
                wgray_reg <= bin2gray(wbin_reg + PTR_W'(1));
            end
        end
    end

    // fall-through counts the output register as one more word of storage
    logic [PTR_W:0] wtotal;
    assign wtotal = {1'b0, wcount_inc} + ((is_ft_w && ov_w2_reg) ? (PTR_W+1)'(1) : '0);

    // full flag raw then second register stage
    // almost-full updated on write clock only
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            full_raw_reg <= 1'b0;
            full_s1_reg <= 1'b0;
            af_raw_reg <= 1'b0;
            hf_raw_reg <= 1'b0;
        end else if (clk_en) begin
            full_raw_reg <= !mr_w_reg && (wcount_inc == DEPTH);
            full_s1_reg <= full_raw_reg;
            af_raw_reg <= !mr_w_reg && (wtotal >= {1'b0, AF_LVL} +
                (is_ft_w ? (PTR_W+1)'(1) : '0));
            hf_raw_reg <= !mr_w_reg && (wtotal > {1'b0, HALF} +
                (is_ft_w ? (PTR_W+1)'(1) : '0));
        end
    end

    // read domain: reset, mode and request synchronisers
    // the mode is steady long before master reset ends, so two flops suffice
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            mr_r_meta_reg <= 1'b0;
            mr_r_reg <= 1'b0;
            mode_r_meta_reg <= 1'b0;
            mode_r_reg <= 1'b0;
            pfm_r_meta_reg <= 1'b0;
            pfm_r_reg <= 1'b0;
            ren_s1_reg <= 1'b1;
            ren_s2_reg <= 1'b1;
        end else if (clk_en) begin
            mr_r_meta_reg <= ~master_reset_n;
            mr_r_reg <= mr_r_meta_reg;
            mode_r_meta_reg <= ft_w_reg;
            mode_r_reg <= mode_r_meta_reg;
            pfm_r_meta_reg <= pfm_reg;
            pfm_r_reg <= pfm_r_meta_reg;
            ren_s1_reg <= read_en_n;
            ren_s2_reg <= ren_s1_reg;
        end
    end

    logic [PTR_W-1:0] wbin_r, rcount;
    logic mem_empty, do_read, load_out;
    assign wbin_r = gray2bin(wgray_r2_reg);
    assign rcount = wbin_r - rbin_reg;
    assign mem_empty = (rcount == '0);
    // fall-through fetch on request, or refill when output empty
    assign load_out = mode_r_reg ? (!mem_empty && (!out_valid_reg || !ren_s2_reg))
                                 : (!mem_empty && !ren_s2_reg);
    assign do_read = load_out && !mr_r_reg;

    // gray read pointer, write pointer synchronised over
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            rbin_reg <= '0;
            rgray_reg <= '0;
            wgray_r1_reg <= '0;
            wgray_r2_reg <= '0;
        end else if (clk_en) begin
            wgray_r1_reg <= wgray_reg;
            wgray_r2_reg <= wgray_r1_reg;
            if (mr_r_reg) begin
                rbin_reg <= '0;
                rgray_reg <= '0;
            end else if (do_read) begin
                rbin_reg <= rbin_reg + PTR_W'(1);
                rgray_reg <= bin2gray(rbin_reg + PTR_W'(1));
            end
        end
    end

    // first word falls through to output register
    // output register holds last word read
    // standard mode keeps the last word shown; fall-through drops valid when consumed
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            read_data_out <= '0;
            out_valid_reg <= 1'b0;
        end else if (clk_en) begin
            if (mr_r_reg) begin
                out_valid_reg <= 1'b0;
            end else if (do_read) begin
                read_data_out <= mem_reg[rbin_reg[ADDR_W-1:0]];
                out_valid_reg <= 1'b1;
            end else if (mode_r_reg && !ren_s2_reg) begin
                // last word consumed, output goes invalid
                out_valid_reg <= 1'b0;
            end
        end
    end

    // output-valid crosses back for the write-side fall-through count; its lag
    // matches that of the read pointer, so a moved word is never counted twice
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            ov_w1_reg <= 1'b0;
            ov_w2_reg <= 1'b0;
        end else if (clk_en) begin
            ov_w1_reg <= out_valid_reg;
            ov_w2_reg <= ov_w1_reg;
        end
    end

    // remaining words as seen by the reader, output register included in fall-through mode
    logic [PTR_W:0] rtotal;
    assign rtotal = {1'b0, rcount} + ((mode_r_reg && out_valid_reg) ? (PTR_W+1)'(1) : '0);

    // almost-empty rises at offset plus one
    // fall-through rises at offset plus two
    // almost-empty updated on read clock only
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            empty_raw_reg <= 1'b1;
            empty_s1_reg <= 1'b1;
            or_pipe_reg <= 2'h3;
            ae_raw_reg <= 1'b1;
        end else if (clk_en) begin
            empty_raw_reg <= mr_r_reg || mem_empty;
            empty_s1_reg <= empty_raw_reg;
            or_pipe_reg <= {or_pipe_reg[0], mr_r_reg || !out_valid_reg};
            ae_raw_reg <= mr_r_reg || (rtotal <= {1'b0, AE_OFS} +
                (mode_r_reg ? (PTR_W+1)'(1) : '0));
        end
    end

    // pin flags gathered in one carrier; the mode picks the empty_n source and which pin shows each
    dcff_flags_t flags_pin;
    assign flags_pin = '{
        empty_n: (mode_r_reg ? or_pipe_reg[1] : ~empty_s1_reg),
        full_n: ~full_s1_reg,
        half_full_n: ~hf_raw_reg,
        almost_empty_n: ~ae_raw_reg,
        almost_full_n: ~af_raw_reg
    };

    // the unused pair of each mode parks high, inactive except input-space, where high means no room
    assign empty_flag_n = mode_r_reg ? 1'b1 : flags_pin.empty_n;
    assign output_ready_n = mode_r_reg ? flags_pin.empty_n : 1'b1;
    assign full_flag_n = is_ft_w ? 1'b1 : flags_pin.full_n;
    assign input_space_n = is_ft_w ? ~flags_pin.full_n : 1'b1;
    assign half_full_n = flags_pin.half_full_n;
    assign almost_full_n = flags_pin.almost_full_n;
    assign almost_empty_n = flags_pin.almost_empty_n;

endmodule : dcff_fifo

`default_nettype wire

// File: tb/dcff_fifo_sva.sv
/* dcff_fifo_chk: flag relation checks for dcff_fifo.
   assumes: bound to dcff_fifo, sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module dcff_fifo_chk (
    input wire logic clk_sys,          // write clock
    input wire logic link_clk,         // read clock
    input wire logic rstn,             // async reset
    input wire logic master_reset_n,   // master reset
    input wire logic empty_flag_n,     // std empty
    input wire logic full_flag_n,      // std full
    input wire logic output_ready_n,   // ft ready
    input wire logic input_space_n,    // ft no room
    input wire logic half_full_n,      // half full
    input wire logic almost_empty_n,   // near empty
    input wire logic almost_full_n,    // near full
    input wire logic fallthrough_mode  // latched mode
);
    // run phase: master reset gone for three edges, so reset-time flags are past
    sequence s_run;
        master_reset_n [*3];
    endsequence
    property p_mode_hold;
        @(posedge clk_sys) disable iff (!rstn) s_run |-> $stable(fallthrough_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
    property p_std_quiet;
        @(posedge link_clk) disable iff (!rstn) (s_run ##0 !fallthrough_mode) |-> output_ready_n;
    endproperty
    a_std_quiet: assert property (p_std_quiet) else $error("ready in std");
    property p_ft_quiet;
        @(posedge link_clk) disable iff (!rstn)
        (s_run ##0 fallthrough_mode) |-> (empty_flag_n && full_flag_n);
    endproperty
    a_ft_quiet: assert property (p_ft_quiet) else $error("std flag in ft");
    property p_full_af;
        @(posedge clk_sys) disable iff (!rstn)
        (s_run ##0 !fallthrough_mode ##0 !full_flag_n) |-> (!almost_full_n && !half_full_n);
    endproperty
    a_full_af: assert property (p_full_af) else $error("full without af");
    property p_af_hf;
        @(posedge clk_sys) disable iff (!rstn) (s_run ##0 !almost_full_n) |-> !half_full_n;
    endproperty
    a_af_hf: assert property (p_af_hf) else $error("af without hf");
    property p_ir_af;
        @(posedge clk_sys) disable iff (!rstn)
        (s_run ##0 fallthrough_mode ##0 input_space_n) |-> !almost_full_n;
    endproperty
    a_ir_af: assert property (p_ir_af) else $error("no room without af");
    property p_empty_ae;
        @(posedge link_clk) disable iff (!rstn)
        (s_run ##0 !fallthrough_mode ##0 $fell(empty_flag_n)) |-> !almost_empty_n;
    endproperty
    a_empty_ae: assert property (p_empty_ae) else $error("empty with ae high");
    property p_or_ae;
        @(posedge link_clk) disable iff (!rstn)
        (s_run ##0 fallthrough_mode ##0 $rose(output_ready_n)) |-> !almost_empty_n;
    endproperty
    a_or_ae: assert property (p_or_ae) else $error("drained with ae high");
endmodule : dcff_fifo_chk
bind dcff_fifo dcff_fifo_chk u_chk (.clk_sys(clk_sys), .link_clk(link_clk), .rstn(rstn),
    .master_reset_n(master_reset_n), .empty_flag_n(empty_flag_n), .full_flag_n(full_flag_n),
    .output_ready_n(output_ready_n), .input_space_n(input_space_n), .half_full_n(half_full_n),
    .almost_empty_n(almost_empty_n), .almost_full_n(almost_full_n),
    .fallthrough_mode(fallthrough_mode));
`default_nettype wire

// File: tb/dcff_reader.sv
/* dcff_reader: reader on the link clock, issues bursts of read requests.
   assumes: bench holds rd_go until rd_done, then drops it. */
`timescale 1ns/1ps
`default_nettype none
module dcff_reader (
    input wire logic link_clk,     // read clock
    input wire logic rstn,         // async reset
    input wire logic rd_go,        // burst request
    input wire logic [7:0] rd_num, // reads in burst
    output logic read_en_n,        // read request
    output logic rd_done           // burst over
);
    logic [7:0] cnt_reg;
    always_ff @(posedge link_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg <= 8'h00;
            read_en_n <= 1'b1;
            rd_done <= 1'b0;
        end else if (rd_go && cnt_reg < rd_num) begin
            read_en_n <= 1'b0;
            cnt_reg <= cnt_reg + 8'h01;
        end else begin
            read_en_n <= 1'b1;
            rd_done <= rd_go;
            if (!rd_go) begin
                cnt_reg <= 8'h00;
            end
        end
    end
endmodule : dcff_reader
`default_nettype wire

// File: tb/dual_clock_fifo_flag_modes_tb.sv
/* dual_clock_fifo_flag_modes_tb: flag and data checks in both timing modes.
   assumes: depth 16, offsets 3; flags settle well inside 80 write clocks. */
`timescale 1ns/1ps
`default_nettype none
module dual_clock_fifo_flag_modes_tb;
    import dcff_pkg::*;
    typedef struct {int cnt; logic [4:0] exp;} dcff_row_t;
    logic clk_sys, link_clk, rstn, mrst_n, ft_sel, wen_n, ren_n, rd_go, rd_done, en;
    logic [35:0] wdata, rdata;
    logic [7:0] rd_num;
    logic e_n, f_n, or_n, ir_n, hf_n, ae_n, af_n, ft;
    int miscompares, compares, seq;
    // empty, full, half, almost empty, almost full per stored count
    dcff_row_t rows [9] = '{'{1, 5'h1d}, '{3, 5'h1d}, '{4, 5'h1f}, '{8, 5'h1f},
        '{9, 5'h1b}, '{12, 5'h1b}, '{13, 5'h1a}, '{16, 5'h12}, '{18, 5'h12}};
    dcff_fifo #(.ADDR_W(4), .EMPTY_OFS(3), .FULL_OFS(3)) u_dut (.clk_sys(clk_sys),
        .rstn(rstn), .clk_en(en), .link_clk(link_clk), .master_reset_n(mrst_n),
        .fallthrough_select_serial_in(ft_sel), .flag_timing_select(1'b1),
        .write_en_n(wen_n), .write_data(wdata), .read_en_n(ren_n), .read_data_out(rdata),
        .empty_flag_n(e_n), .full_flag_n(f_n), .output_ready_n(or_n),
        .input_space_n(ir_n), .half_full_n(hf_n), .almost_empty_n(ae_n),
        .almost_full_n(af_n), .fallthrough_mode(ft));
    dcff_reader u_rd (.link_clk(link_clk), .rstn(rstn), .rd_go(rd_go), .rd_num(rd_num),
        .read_en_n(ren_n), .rd_done(rd_done));
    // clocks: link clock phase offset so edges never line up
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    function automatic logic [35:0] word(int i);
        return 36'h0a0000000 + 36'(i);
    endfunction : word
    task automatic check(string name, logic [35:0] exp, logic [35:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic ticks(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : ticks
    task automatic stop_test();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : stop_test
    // writer: back to back words, data held with the strobe
    task automatic write_words(int n);
        for (int i = 0; i < n; i++) begin
            wen_n = 1'b0;
            wdata = word(seq);
            seq++;
            ticks(1);
        end
        wen_n = 1'b1;
    endtask : write_words
    task automatic read_burst(int n);
        int k;
        rd_num = 8'(n);
        rd_go = 1'b1;
        for (k = 0; k < 400 && rd_done !== 1'b1; k++) ticks(1);
        if (k == 400) begin
            miscompares++;
            stop_test();
        end
        rd_go = 1'b0;
        ticks(80);
    endtask : read_burst
    task automatic master_reset(logic mode);
        mrst_n = 1'b0;
        ft_sel = mode;
        ticks(30);
        mrst_n = 1'b1;
        ticks(4);
    endtask : master_reset
    // fall-through fill step: n more words, then half, almost-empty, almost-full
    task automatic ft_step(int n, logic [2:0] exp);
        write_words(n);
        ticks(80);
        check("ft levels", {33'h0, exp}, {33'h0, hf_n, ae_n, af_n});
    endtask : ft_step
    function automatic logic [35:0] flags();
        return {31'h0, e_n, f_n, hf_n, ae_n, af_n};
    endfunction : flags
    initial begin
        int wr;
        {rstn, mrst_n, ft_sel, wen_n, rd_go, wdata, rd_num} = {3'b000, 2'b10, 36'h0, 8'h00};
        en = 1'b1;
        miscompares = 0;
        compares = 0;
        seq = 0;
        wr = 0;
        ticks(16);
        rstn = 1'b1;
        mrst_n = 1'b0;
        ticks(30);
        check("reset flags", {34'h0, 2'b01}, {34'h0, e_n, f_n});
        master_reset(1'b0);
        check("std mode", 36'h0, {35'h0, ft});
        foreach (rows[i]) begin
            write_words(rows[i].cnt - wr);
            wr = rows[i].cnt;
            ticks(80);
            check("std flags", {31'h0, rows[i].exp}, flags());
        end
        read_burst(1);
        check("first word", word(0), rdata);
        check("after one read", 36'h1a, flags());
        read_burst(20);
        check("last word", word(15), rdata);
        check("drained flags", 36'h0d, flags());
        master_reset(1'b1);
        write_words(1);
        ticks(80);
        check("ft mode", 36'h1, {35'h0, ft});
        check("fall through", word(18), rdata);
        check("ready", 36'h0, {35'h0, or_n});
        ft_step(3, 3'b101);
        ft_step(1, 3'b111);
        ft_step(4, 3'b111);
        ft_step(1, 3'b011);
        ft_step(3, 3'b011);
        ft_step(1, 3'b010);
        write_words(5);
        ticks(80);
        check("no room", 36'h4, {33'h0, ir_n, af_n, hf_n});
        read_burst(1);
        check("second word", word(19), rdata);
        check("room again", 36'h0, {35'h0, ir_n});
        read_burst(20);
        check("ft last", word(34), rdata);
        check("ft drained", 36'h2, {34'h0, or_n, ae_n});
        // clock enable low freezes both domains: a write offered meanwhile is never taken
        en = 1'b0;
        ticks(2);
        write_words(2);
        ticks(80);
        check("frozen", 36'h1, {35'h0, or_n});
        en = 1'b1;
        ticks(80);
        check("thawed", 36'h1, {35'h0, or_n});
        stop_test();
    end
endmodule : dual_clock_fifo_flag_modes_tb
`default_nettype wire
